// ==== verif/btsp_props.sv ====
// assertions on the scan and shutdown ports
`timescale 1ns/1ns
`default_nettype none
`include "btsp_defs.vh"
module btsp_props #(parameter integer CELLS = 7) (
   input wire logic clk_sys, resetn, thermistor_supply_force_on, switch_we,
   input wire logic internal_overtemp_response_off, external_overtemp_response_off,
   input wire logic charge_overcurrent_flag, discharge_overcurrent_flag, short_circuit_flag,
   input wire logic [3:0] monitor_mux_select_wdata, monitor_mux_select,
   input wire logic monitor_mux_select_we, thermistor_supply_out, charge_switch_on,
   input wire logic discharge_switch_on, internal_overtemp_flag, external_overtemp_flag,
   input wire logic overtemp_shutdown,
   input wire logic [CELLS-1:0] cell_balance_on
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence trip; $rose(overtemp_shutdown); endsequence
   sequence both_off; internal_overtemp_response_off && external_overtemp_response_off;
   endsequence
   a_force_on: assert property (thermistor_supply_force_on |=> thermistor_supply_out)
      else $error("supply off while forced on");
   a_wake_supply: assert property ((charge_overcurrent_flag || discharge_overcurrent_flag
      || short_circuit_flag) |=> thermistor_supply_out) else $error("no wake on supply pin");
   a_ext_supply: assert property (monitor_mux_select == `BTSP_SEL_EXT_TEMP
      |=> thermistor_supply_out) else $error("supply off with external select");
   a_mux_write: assert property (monitor_mux_select_we
      |=> monitor_mux_select == $past(monitor_mux_select_wdata)) else $error("select not stored");
   a_trip_flag: assert property (trip |-> internal_overtemp_flag || external_overtemp_flag)
      else $error("shutdown without flag");
   a_hold_off: assert property (overtemp_shutdown [*2] |-> !charge_switch_on
      && !discharge_switch_on && cell_balance_on == '0) else $error("outputs on in shutdown");
   a_write_ignored: assert property (overtemp_shutdown && switch_we ##1 overtemp_shutdown
      |-> !charge_switch_on && !discharge_switch_on) else $error("switch write taken");
   a_no_response: assert property (both_off [*2] |=> !$rose(overtemp_shutdown))
      else $error("shutdown with responses off");
endmodule // btsp_props
bind btsp_top btsp_props #(.CELLS(CELLS)) u_props (.*);
`default_nettype wire

// ==== verif/btsp_therm_model.sv ====
// thermistor divider and comparator on the supply pin
`timescale 1ns/1ns
`default_nettype none
module btsp_therm_model (
   input wire logic supply,
   input wire logic hot,
   output logic sense
);
   // unpowered divider sits at 0 v, below the supply/13 reference
   assign sense = supply && !hot;
endmodule // btsp_therm_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// testbench for the scan and shutdown block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk_sys = 1'b0, resetn = 1'b0, auto_scan_disable = 1'b0, thermistor_supply_force_on = 1'b0;
   logic internal_overtemp_response_off = 1'b0, external_overtemp_response_off = 1'b0, hot = 1'b0;
   logic [3:0] monitor_mux_select_wdata = 4'h0, monitor_mux_select;
   logic monitor_mux_select_we = 1'b0, charge_switch_wdata = 1'b0, discharge_switch_wdata = 1'b0;
   logic switch_we = 1'b0, cell_balance_we = 1'b0, flag_clear = 1'b0, internal_overtemp_in = 1'b0;
   logic internal_recovered_in = 1'b1, external_recovered_in = 1'b0, short_circuit_flag = 1'b0;
   logic charge_overcurrent_flag = 1'b0, discharge_overcurrent_flag = 1'b0;
   logic [6:0] cell_balance_wdata = 7'h00, cell_balance_on;
   logic thermistor_sense_in, thermistor_supply_out, charge_switch_on, discharge_switch_on;
   logic internal_overtemp_flag, external_overtemp_flag, overtemp_shutdown;
   int errors = 0, num_checks = 0, cnt;
   // rows: expected supply in bit 4, select code in bits 3:0
   logic [4:0] rows [4] = '{5'h00, 5'h18, 5'h09, 5'h05};
   always #10 clk_sys = ~clk_sys;
   btsp_top #(.TICK_CYC(4)) u_dut (.*);
   btsp_therm_model u_therm (.supply(thermistor_supply_out), .hot(hot), .sense(thermistor_sense_in));
   task automatic tk(input int n); repeat (n) @(posedge clk_sys); endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      if (errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic sel(input logic [3:0] v);
      tk(1); monitor_mux_select_wdata <= v; monitor_mux_select_we <= 1'b1;
      tk(1); monitor_mux_select_we <= 1'b0;
   endtask
   task automatic count_on(input int n);
      cnt = 0;
      repeat (n) begin @(negedge clk_sys); if (thermistor_supply_out === 1'b1) cnt++; end
   endtask
   initial begin
      tk(8); @(negedge clk_sys);
      chk({2'b00, thermistor_supply_out, overtemp_shutdown, monitor_mux_select}, 8'h00);
      tk(1); resetn <= 1'b1;
      count_on(2560); count_on(2560); chk(cnt[7:0], 8'd20);
      chk(external_overtemp_flag, 8'h00);
      tk(1); auto_scan_disable <= 1'b1; tk(40);
      count_on(2600); chk(cnt[7:0], 8'h00);
      foreach (rows[i]) begin
         sel(rows[i][3:0]); tk(2); @(negedge clk_sys);
         chk({3'b000, thermistor_supply_out, monitor_mux_select}, {3'b000, rows[i]});
      end
      tk(1); thermistor_supply_force_on <= 1'b1; tk(2); @(negedge clk_sys);
      chk(thermistor_supply_out, 8'h01);
      tk(1); thermistor_supply_force_on <= 1'b0; short_circuit_flag <= 1'b1; tk(2); @(negedge clk_sys);
      chk(thermistor_supply_out, 8'h01);
      tk(1); short_circuit_flag <= 1'b0; charge_switch_wdata <= 1'b1; discharge_switch_wdata <= 1'b1;
      switch_we <= 1'b1; cell_balance_wdata <= 7'h55; cell_balance_we <= 1'b1;
      tk(1); switch_we <= 1'b0; cell_balance_we <= 1'b0; tk(3); @(negedge clk_sys);
      chk({charge_switch_on & discharge_switch_on, cell_balance_on}, 8'hd5);
      tk(1); hot <= 1'b1; sel(4'h8);
      for (cnt = 0; cnt < 40 && overtemp_shutdown !== 1'b1; cnt++) tk(1);
      if (cnt == 40) begin errors++; print_verdict; end
      @(negedge clk_sys);
      chk({2'b00, internal_overtemp_flag, external_overtemp_flag, overtemp_shutdown, charge_switch_on,
         discharge_switch_on, |cell_balance_on}, 8'h18);
      tk(1); switch_we <= 1'b1; cell_balance_we <= 1'b1; tk(1); switch_we <= 1'b0; cell_balance_we <= 1'b0;
      sel(4'h9); tk(2); @(negedge clk_sys);
      chk({1'b0, monitor_mux_select, charge_switch_on, discharge_switch_on, |cell_balance_on}, 8'h48);
      tk(1); hot <= 1'b0; external_recovered_in <= 1'b1; tk(4); @(negedge clk_sys);
      chk({overtemp_shutdown, charge_switch_on, discharge_switch_on}, 8'h00);
      tk(1); external_recovered_in <= 1'b0; hot <= 1'b1;
      internal_overtemp_response_off <= 1'b1; external_overtemp_response_off <= 1'b1;
      sel(4'h8); tk(12); @(negedge clk_sys);
      chk(overtemp_shutdown, 8'h00);
      tk(1); internal_overtemp_in <= 1'b1; internal_recovered_in <= 1'b0; switch_we <= 1'b1;
      tk(1); switch_we <= 1'b0; tk(2); @(negedge clk_sys);
      chk({overtemp_shutdown, charge_switch_on, discharge_switch_on}, 8'h03);
      tk(1); charge_switch_wdata <= 1'b0; discharge_switch_wdata <= 1'b0; switch_we <= 1'b1;
      tk(1); switch_we <= 1'b0; tk(1); @(negedge clk_sys);
      chk({charge_switch_on, discharge_switch_on}, 8'h00);
      tk(1); internal_overtemp_response_off <= 1'b0; flag_clear <= 1'b1;
      tk(1); flag_clear <= 1'b0; tk(1); @(negedge clk_sys);
      chk({internal_overtemp_flag, overtemp_shutdown}, 8'h03);
      tk(1); internal_overtemp_in <= 1'b0; internal_recovered_in <= 1'b1; hot <= 1'b0;
      flag_clear <= 1'b1;
      tk(1); flag_clear <= 1'b0; tk(2); @(negedge clk_sys);
      chk({internal_overtemp_flag, external_overtemp_flag, overtemp_shutdown}, 8'h00);
      print_verdict;
   end
endmodule // tb_top
`default_nettype wire

// ==== verilog/btsp_defs.vh ====
// constants for the battery temperature scan and protection block
// Behaviour
// (R1) by default supply on 5 ms at start of each 640 ms period
// (R2) sample external comparator 1 ms after supply on; low voltage means failure
// (R3) mux on external temperature keeps supply on, detection enabled after 1 ms; code enables it at the next tick, 1 clock to 1 ms later
// (R4) scan disable bit stops periodic scan; both scans coexist otherwise
// (R5) force-on bit holds supply on always, overriding both scans
// (R6) over-temperature turns switches off, blocks balancing, sets matching flag
// (R7) shutdown holds until temperature drops below recovery threshold
// (R8) during shutdown host writes to switch and balance bits are ignored
// (R9) internal response off bit stops shutdown for internal over-temperature
// (R10) external response off bit stops shutdown for external over-temperature
// (R11) with a response disabled, host protects the pack itself
// (R12) host writes four-bit mux select; device routes chosen source
// (R13) one balance bit per cell turns that cell's switch on
// (R14) any overcurrent or short flag drives thermistor supply high
// (R15) automatic switch turn-off also clears the switch control bits
// (R16) timing from a fixed tick; counters restart at reset
// (R17) comparator ignored while supply off or settling
`ifndef BTSP_DEFS_VH
`define BTSP_DEFS_VH
`define BTSP_CLK_HZ 50000000
`define BTSP_TICK_US 1000
`define BTSP_TICK_CYC ((`BTSP_CLK_HZ / 1000000) * `BTSP_TICK_US)
`define BTSP_PERIOD_MS 640
`define BTSP_ON_MS 5
`define BTSP_SETTLE_MS 1
`define BTSP_PERIOD_TICKS (`BTSP_PERIOD_MS * 1000 / `BTSP_TICK_US)
`define BTSP_ON_TICKS (`BTSP_ON_MS * 1000 / `BTSP_TICK_US)
`define BTSP_SETTLE_TICKS (`BTSP_SETTLE_MS * 1000 / `BTSP_TICK_US)
`define BTSP_SEL_EXT_TEMP 4'h8
`define BTSP_SEL_INT_TEMP 4'h9
`define BTSP_SEL_RST 4'h0
`endif

// ==== verilog/btsp_top.v ====
// thermistor supply scan, over-temperature shutdown, mux select and balance drive
`timescale 1ns/1ns
`default_nettype none
`include "btsp_defs.vh"
module btsp_top #(
   parameter integer CELLS = 7,
   parameter integer TICK_CYC = `BTSP_TICK_CYC,
   parameter integer PERIOD_TICKS = `BTSP_PERIOD_TICKS,
   parameter integer ON_TICKS = `BTSP_ON_TICKS,
   parameter integer SETTLE_TICKS = `BTSP_SETTLE_TICKS
) (
   input wire clk_sys,
   input wire resetn,
   input wire auto_scan_disable,
   input wire thermistor_supply_force_on,
   input wire internal_overtemp_response_off,
   input wire external_overtemp_response_off,
   input wire [3:0] monitor_mux_select_wdata,
   input wire monitor_mux_select_we,
   input wire charge_switch_wdata,
   input wire discharge_switch_wdata,
   input wire switch_we,
   input wire [CELLS-1:0] cell_balance_wdata,
   input wire cell_balance_we,
   input wire flag_clear,
   input wire thermistor_sense_in,
   input wire internal_overtemp_in,
   input wire internal_recovered_in,
   input wire external_recovered_in,
   input wire charge_overcurrent_flag,
   input wire discharge_overcurrent_flag,
   input wire short_circuit_flag,
   output reg thermistor_supply_out,
   output reg [3:0] monitor_mux_select,
   output reg charge_switch_on,
   output reg discharge_switch_on,
   output reg [CELLS-1:0] cell_balance_on,
   output reg internal_overtemp_flag,
   output reg external_overtemp_flag,
   output reg overtemp_shutdown
);

////////////////////////////////////////////////////////////////////////////////
// state and decode nets
reg [15:0] tick_cnt_r;
reg tick_r;
reg [9:0] period_cnt_r;
reg [9:0] settle_cnt_r;
reg [CELLS-1:0] bal_req_r;
reg int_sd_r;
reg ext_sd_r;
reg auto_on;
reg manual_on;
reg supply_req;
reg wake_req;
reg settled;
reg ext_fail;
reg int_trip;
reg ext_trip;
reg sd_nxt;
genvar cell_i;

////////////////////////////////////////////////////////////////////////////////
// fixed tick: one pulse every TICK_CYC clocks
always @(posedge clk_sys) begin
   if (!resetn) begin
      tick_cnt_r <= 16'h0000;
   end else if (tick_cnt_r == TICK_CYC[15:0] - 16'h0001) begin
      tick_cnt_r <= 16'h0000; // see (R16)
   end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
   end
end

always @(posedge clk_sys) begin
   if (!resetn) begin
      tick_r <= 1'b0;
   end else begin
      tick_r <= (tick_cnt_r == TICK_CYC[15:0] - 16'h0001); // see (R16)
   end
end

////////////////////////////////////////////////////////////////////////////////
// scan period counter, advanced once per tick
always @(posedge clk_sys) begin
   if (!resetn) begin
      period_cnt_r <= 10'h000;
   end else if (tick_r) begin
      if (period_cnt_r == PERIOD_TICKS[9:0] - 10'h001) begin
         period_cnt_r <= 10'h000; // see (R1)
      end else begin
         period_cnt_r <= period_cnt_r + 10'h001;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// supply requests from the periodic scan, the host select and force-on
always @* begin
   auto_on = 1'b0;
   if (!auto_scan_disable && (period_cnt_r < ON_TICKS[9:0])) begin
      auto_on = 1'b1; // see (R1) see (R4)
   end
end

always @* begin
   manual_on = 1'b0;
   if (monitor_mux_select == `BTSP_SEL_EXT_TEMP) begin
      manual_on = 1'b1; // see (R3)
   end
end

always @* begin
   supply_req = thermistor_supply_force_on | auto_on | manual_on; // see (R5) see (R4)
end

// overcurrent flags reuse the supply pin as a host wake-up line
always @* begin
   wake_req = charge_overcurrent_flag | discharge_overcurrent_flag | short_circuit_flag;
end

////////////////////////////////////////////////////////////////////////////////
// settling delay, restarted whenever the supply request drops
always @(posedge clk_sys) begin
   if (!resetn) begin
      settle_cnt_r <= 10'h000;
   end else if (!supply_req) begin
      settle_cnt_r <= 10'h000;
   end else if (tick_r && (settle_cnt_r < SETTLE_TICKS[9:0])) begin
      settle_cnt_r <= settle_cnt_r + 10'h001; // see (R2) see (R3)
   end
end

always @* begin
   settled = 1'b0;
   if (supply_req && (settle_cnt_r >= SETTLE_TICKS[9:0])) begin
      settled = 1'b1; // see (R2) see (R3)
   end
end

////////////////////////////////////////////////////////////////////////////////
// comparator gating and trip decode
// low sense level means the divider sits below the supply/13 reference
always @* begin
   ext_fail = 1'b0;
   if (settled && !thermistor_sense_in) begin
      ext_fail = 1'b1; // see (R2) see (R17)
   end
end

always @* begin
   int_trip = 1'b0;
   if (internal_overtemp_in && !internal_overtemp_response_off) begin
      int_trip = 1'b1; // see (R9)
   end
end

always @* begin
   ext_trip = 1'b0;
   if (ext_fail && !external_overtemp_response_off) begin
      ext_trip = 1'b1; // see (R10)
   end
end

always @* begin
   sd_nxt = int_sd_r | ext_sd_r | int_trip | ext_trip;
end

////////////////////////////////////////////////////////////////////////////////
// internal shutdown latch, trip has priority over recovery
always @(posedge clk_sys) begin
   if (!resetn) begin
      int_sd_r <= 1'b0;
   end else if (int_trip) begin
      int_sd_r <= 1'b1; // see (R6)
   end else if (internal_recovered_in) begin
      int_sd_r <= 1'b0; // see (R7)
   end
end

////////////////////////////////////////////////////////////////////////////////
// external shutdown latch
always @(posedge clk_sys) begin
   if (!resetn) begin
      ext_sd_r <= 1'b0;
   end else if (ext_trip) begin
      ext_sd_r <= 1'b1; // see (R6)
   end else if (external_recovered_in) begin
      ext_sd_r <= 1'b0; // see (R7)
   end
end

////////////////////////////////////////////////////////////////////////////////
// internal status flag, a new event wins over a host clear
always @(posedge clk_sys) begin
   if (!resetn) begin
      internal_overtemp_flag <= 1'b0;
   end else if (internal_overtemp_in) begin
      internal_overtemp_flag <= 1'b1; // see (R6)
   end else if (flag_clear) begin
      internal_overtemp_flag <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// external status flag, set only from a settled comparator reading
always @(posedge clk_sys) begin
   if (!resetn) begin
      external_overtemp_flag <= 1'b0;
   end else if (ext_fail) begin
      external_overtemp_flag <= 1'b1; // see (R6)
   end else if (flag_clear) begin
      external_overtemp_flag <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// combined shutdown state seen by the host
always @(posedge clk_sys) begin
   if (!resetn) begin
      overtemp_shutdown <= 1'b0;
   end else begin
      overtemp_shutdown <= sd_nxt; // see (R6) see (R7)
   end
end

////////////////////////////////////////////////////////////////////////////////
// thermistor supply pin
always @(posedge clk_sys) begin
   if (!resetn) begin
      thermistor_supply_out <= 1'b0;
   end else begin
      thermistor_supply_out <= supply_req | wake_req; // see (R14)
   end
end

////////////////////////////////////////////////////////////////////////////////
// analog monitor select, still writable during shutdown
always @(posedge clk_sys) begin
   if (!resetn) begin
      monitor_mux_select <= `BTSP_SEL_RST;
   end else if (monitor_mux_select_we) begin
      monitor_mux_select <= monitor_mux_select_wdata; // see (R12) see (R8)
   end
end

////////////////////////////////////////////////////////////////////////////////
// charge switch bit: cleared on shutdown, host writes ignored meanwhile
always @(posedge clk_sys) begin
   if (!resetn) begin
      charge_switch_on <= 1'b0;
   end else if (sd_nxt) begin
      charge_switch_on <= 1'b0; // see (R6) see (R15)
   end else if (switch_we) begin
      charge_switch_on <= charge_switch_wdata; // see (R8)
   end
end

////////////////////////////////////////////////////////////////////////////////
// discharge switch bit
always @(posedge clk_sys) begin
   if (!resetn) begin
      discharge_switch_on <= 1'b0;
   end else if (sd_nxt) begin
      discharge_switch_on <= 1'b0; // see (R6) see (R15)
   end else if (switch_we) begin
      discharge_switch_on <= discharge_switch_wdata; // see (R8)
   end
end

////////////////////////////////////////////////////////////////////////////////
// per-cell balance request and switch drive; shutdown blocks both
generate
   for (cell_i = 0; cell_i < CELLS; cell_i = cell_i + 1) begin : g_cell
      always @(posedge clk_sys) begin
         if (!resetn) begin
            bal_req_r[cell_i] <= 1'b0;
         end else if (cell_balance_we && !sd_nxt) begin
            bal_req_r[cell_i] <= cell_balance_wdata[cell_i]; // see (R8) see (R13)
         end
      end

      always @(posedge clk_sys) begin
         if (!resetn) begin
            cell_balance_on[cell_i] <= 1'b0;
         end else if (sd_nxt) begin
            cell_balance_on[cell_i] <= 1'b0; // see (R6) see (R7)
         end else begin
            cell_balance_on[cell_i] <= bal_req_r[cell_i]; // see (R13)
         end
      end
   end
endgenerate

endmodule // btsp_top
`default_nettype wire
